// >>> hdl/capture_compare_timer.sv
// Multi-channel 16-bit capture/compare timer with precision prescaler
//
// Decided for this implementation: the strobed register port.
`include "capture_compare_timer_regs.svh"
`default_nettype none
module capture_compare_timer #(
  parameter int CHANNELS = 6
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [`CCT_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [CHANNELS-1:0] ch_pin_in,
  output logic [CHANNELS-1:0] ch_pin_out,
  output logic [CHANNELS-1:0] ch_pin_oe_n,
  output logic [CHANNELS-1:0] channel_irq,
  output logic overflow_irq
);

  localparam int PAD = 8 - CHANNELS;

  // ==========================================================
  // Register state
  capture_compare_timer_pkg::system_control_t system_control_one_q;
  capture_compare_timer_pkg::system_control_two_t system_control_two_q;
  logic [7:0] precision_prescale_select_q;
  logic [CHANNELS-1:0] channel_direction_select_q;
  logic [CHANNELS-1:0] channel_irq_enable_q;
  logic [CHANNELS-1:0] pin_disconnect_q;
  logic [CHANNELS-1:0] compare_action_mode_q;
  logic [CHANNELS-1:0] compare_action_level_q;
  logic [CHANNELS-1:0] edge_rise_q;
  logic [CHANNELS-1:0] edge_fall_q;
  logic [CHANNELS-1:0] port_latch_q;
  logic [CHANNELS-1:0] channel_event_flag_q;
  logic overflow_flag_q;
  logic [15:0] channel_capture_compare_value_q [CHANNELS];
  logic [15:0] free_running_counter_q;
  logic [CHANNELS-1:0] output_state_q;
  logic [CHANNELS-1:0] pin_out_q;
  logic [CHANNELS-1:0] pin_oe_n_q;
  logic [7:0] rdata_q;

  logic timer_enable;
  assign timer_enable = system_control_one_q.timer_enable;

  // ==========================================================
  // Address decode
  logic chan_access;
  logic [2:0] chan_index;
  logic wr_flags;
  logic wr_force;
  logic count_access;

  assign chan_access = (addr[5:4] == `CCT_OFS_CHAN_BASE_HI);
  assign chan_index = addr[3:1];
  assign wr_flags = wr && (addr == `CCT_OFS_CHAN_FLAGS);
  assign wr_force = wr && (addr == `CCT_OFS_FORCE);
  assign count_access = (rd || wr) &&
                        (addr == `CCT_OFS_COUNT_HI || addr == `CCT_OFS_COUNT_LO);

  // ==========================================================
  // Control register writes
  always_ff @(posedge clock) begin
    if (!rstn) begin
      system_control_one_q <= '0;
      system_control_two_q <= '0;
      precision_prescale_select_q <= `CCT_RST_BYTE;
      channel_direction_select_q <= '0;
      channel_irq_enable_q <= '0;
      pin_disconnect_q <= '0;
      port_latch_q <= '0;
    end else if (wr) begin
      unique case (addr)
        `CCT_OFS_SYS_CTRL_ONE: begin
          system_control_one_q.timer_enable <= wdata[`CCT_BIT_TEN];
          system_control_one_q.fast_flag_clear <= wdata[`CCT_BIT_FFCA];
          system_control_one_q.fine_prescale_select <= wdata[`CCT_BIT_FINE];
        end
        `CCT_OFS_SYS_CTRL_TWO: begin
          system_control_two_q.overflow_irq_enable <= wdata[`CCT_BIT_OVF_IRQ];
          system_control_two_q.coarse_divider_select <=
            wdata[`CCT_POS_COARSE +: `CCT_W_COARSE];
        end
        `CCT_OFS_PRECISION: precision_prescale_select_q <= wdata;
        `CCT_OFS_DIRECTION: channel_direction_select_q <= wdata[CHANNELS-1:0];
        `CCT_OFS_IRQ_ENABLE: channel_irq_enable_q <= wdata[CHANNELS-1:0];
        `CCT_OFS_DISCONNECT: pin_disconnect_q <= wdata[CHANNELS-1:0];
        `CCT_OFS_PORT_LATCH: port_latch_q <= wdata[CHANNELS-1:0];
        default: begin
        end
      endcase
    end
  end

  // Mode/level and edge pairs, four channels per byte, high byte holds upper ones
  always_ff @(posedge clock) begin
    if (!rstn) begin
      compare_action_mode_q <= '0;
      compare_action_level_q <= '0;
      edge_rise_q <= '0;
      edge_fall_q <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (i >= `CCT_PAIRS_PER_BYTE) begin
          if (wr && addr == `CCT_OFS_ACTION_HI) begin
            compare_action_mode_q[i] <= wdata[2*(i-`CCT_PAIRS_PER_BYTE)+1];
            compare_action_level_q[i] <= wdata[2*(i-`CCT_PAIRS_PER_BYTE)];
          end
          if (wr && addr == `CCT_OFS_EDGE_HI) begin
            edge_fall_q[i] <= wdata[2*(i-`CCT_PAIRS_PER_BYTE)+1];
            edge_rise_q[i] <= wdata[2*(i-`CCT_PAIRS_PER_BYTE)];
          end
        end else begin
          if (wr && addr == `CCT_OFS_ACTION_LO) begin
            compare_action_mode_q[i] <= wdata[2*i+1];
            compare_action_level_q[i] <= wdata[2*i];
          end
          if (wr && addr == `CCT_OFS_EDGE_LO) begin
            edge_fall_q[i] <= wdata[2*i+1];
            edge_rise_q[i] <= wdata[2*i];
          end
        end
      end
    end
  end

  // ==========================================================
  // Prescaler
  logic [7:0] prescale_cnt_q;
  logic [7:0] active_div_q;
  logic [7:0] selected_div;
  logic [7:0] cur_div;
  logic [8:0] coarse_div;
  logic tick;

  assign coarse_div = (9'h001 << system_control_two_q.coarse_divider_select) - 9'h001;
  assign selected_div = system_control_one_q.fine_prescale_select ?
                        precision_prescale_select_q : coarse_div[7:0];
  // At a zero stage the freshly selected factor already counts
  assign cur_div = (prescale_cnt_q == 8'h00) ? selected_div : active_div_q;
  assign tick = timer_enable && (prescale_cnt_q == cur_div);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      prescale_cnt_q <= `CCT_RST_BYTE;
      active_div_q <= `CCT_RST_BYTE;
    end else begin
      if (!timer_enable || tick) begin
        prescale_cnt_q <= `CCT_RST_BYTE;
      end else begin
        prescale_cnt_q <= prescale_cnt_q + 8'h01;
      end
      if (prescale_cnt_q == 8'h00) begin
        active_div_q <= selected_div;
      end
    end
  end

  // ==========================================================
  // Free-running counter
  logic overflow_event;
  logic advanced_q;

  assign overflow_event = tick && (free_running_counter_q == `CCT_COUNT_MAX);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      free_running_counter_q <= `CCT_RST_WORD;
      advanced_q <= 1'b0;
    end else begin
      advanced_q <= tick;
      if (tick) begin
        free_running_counter_q <= free_running_counter_q + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Channel events
  logic [CHANNELS-1:0] edge_seen;
  logic [CHANNELS-1:0] capture_event;
  logic [CHANNELS-1:0] compare_event;
  logic [CHANNELS-1:0] force_event;
  logic [CHANNELS-1:0] fast_clear;

  capture_edge_detect #(
    .WIDTH(CHANNELS)
  ) edge_detect (
    .clock(clock),
    .rstn(rstn),
    .pin_in(ch_pin_in),
    .rise_enable(edge_rise_q),
    .fall_enable(edge_fall_q),
    .edge_seen(edge_seen)
  );

  for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
    assign capture_event[g] = timer_enable && !channel_direction_select_q[g] && edge_seen[g];
    assign compare_event[g] = timer_enable && channel_direction_select_q[g] && advanced_q &&
      (free_running_counter_q == channel_capture_compare_value_q[g]);
    assign force_event[g] = wr_force && wdata[g] && timer_enable &&
      channel_direction_select_q[g];
    assign fast_clear[g] = system_control_one_q.fast_flag_clear && chan_access &&
      (chan_index == 3'(g)) &&
      ((rd && !channel_direction_select_q[g]) || (wr && channel_direction_select_q[g]));
  end

  // Capture latch and compare value writes
  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int i = 0; i < CHANNELS; i++) begin
        channel_capture_compare_value_q[i] <= `CCT_RST_WORD;
      end
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (capture_event[i]) begin
          channel_capture_compare_value_q[i] <= free_running_counter_q;
        end else if (wr && chan_access && chan_index == 3'(i) &&
                     channel_direction_select_q[i]) begin
          if (addr[0]) begin
            channel_capture_compare_value_q[i][7:0] <= wdata;
          end else begin
            channel_capture_compare_value_q[i][15:8] <= wdata;
          end
        end
      end
    end
  end

  // ==========================================================
  // Flags: a set in the clearing cycle wins
  always_ff @(posedge clock) begin
    if (!rstn) begin
      channel_event_flag_q <= '0;
      overflow_flag_q <= 1'b0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (capture_event[i] || compare_event[i]) begin
          channel_event_flag_q[i] <= 1'b1;
        end else if ((wr_flags && wdata[i] && timer_enable) || fast_clear[i]) begin
          channel_event_flag_q[i] <= 1'b0;
        end
      end
      if (overflow_event) begin
        overflow_flag_q <= 1'b1;
      end else if ((wr && addr == `CCT_OFS_OVF_FLAGS && wdata[`CCT_BIT_OVF_FLAG] &&
                    timer_enable) ||
                   (system_control_one_q.fast_flag_clear && count_access)) begin
        overflow_flag_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Compare output register and pin
  function automatic logic apply_action(input logic mode, input logic level,
                                        input logic current);
    capture_compare_timer_pkg::compare_action_t act;
    act = capture_compare_timer_pkg::compare_action_t'({mode, level});
    unique case (act)
      capture_compare_timer_pkg::act_none: apply_action = current;
      capture_compare_timer_pkg::act_toggle: apply_action = !current;
      capture_compare_timer_pkg::act_clear: apply_action = 1'b0;
      capture_compare_timer_pkg::act_set: apply_action = 1'b1;
    endcase
  endfunction : apply_action

  always_ff @(posedge clock) begin
    if (!rstn) begin
      output_state_q <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (force_event[i] || compare_event[i]) begin
          output_state_q[i] <= apply_action(compare_action_mode_q[i],
                                            compare_action_level_q[i],
                                            output_state_q[i]);
        end
      end
    end
  end

  // Pin follows the output register only while connected
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pin_out_q <= '0;
      pin_oe_n_q <= '1;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        pin_out_q[i] <= (channel_direction_select_q[i] && !pin_disconnect_q[i]) ?
                        output_state_q[i] : port_latch_q[i];
        pin_oe_n_q[i] <= !channel_direction_select_q[i];
      end
    end
  end

  assign ch_pin_out = pin_out_q;
  assign ch_pin_oe_n = pin_oe_n_q;

  // ==========================================================
  // Interrupt outputs
  assign channel_irq = channel_event_flag_q & channel_irq_enable_q;
  assign overflow_irq = overflow_flag_q && system_control_two_q.overflow_irq_enable;

  // ==========================================================
  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata_q <= `CCT_RST_BYTE;
    end else if (!rd) begin
      rdata_q <= `CCT_RST_BYTE;
    end else if (chan_access) begin
      rdata_q <= `CCT_RST_BYTE;
      for (int i = 0; i < CHANNELS; i++) begin
        if (chan_index == 3'(i)) begin
          rdata_q <= addr[0] ? channel_capture_compare_value_q[i][7:0] :
                               channel_capture_compare_value_q[i][15:8];
        end
      end
    end else begin
      unique case (addr)
        `CCT_OFS_DIRECTION: rdata_q <= {{PAD{1'b0}}, channel_direction_select_q};
        `CCT_OFS_COUNT_HI: rdata_q <= free_running_counter_q[15:8];
        `CCT_OFS_COUNT_LO: rdata_q <= free_running_counter_q[7:0];
        `CCT_OFS_SYS_CTRL_ONE: rdata_q <= {system_control_one_q.timer_enable, 2'h0,
                                           system_control_one_q.fast_flag_clear,
                                           system_control_one_q.fine_prescale_select,
                                           3'h0};
        `CCT_OFS_ACTION_HI: rdata_q <= {4'h0,
                                        compare_action_mode_q[5], compare_action_level_q[5],
                                        compare_action_mode_q[4], compare_action_level_q[4]};
        `CCT_OFS_ACTION_LO: rdata_q <= {compare_action_mode_q[3], compare_action_level_q[3],
                                        compare_action_mode_q[2], compare_action_level_q[2],
                                        compare_action_mode_q[1], compare_action_level_q[1],
                                        compare_action_mode_q[0], compare_action_level_q[0]};
        `CCT_OFS_EDGE_HI: rdata_q <= {4'h0, edge_fall_q[5], edge_rise_q[5],
                                      edge_fall_q[4], edge_rise_q[4]};
        `CCT_OFS_EDGE_LO: rdata_q <= {edge_fall_q[3], edge_rise_q[3],
                                      edge_fall_q[2], edge_rise_q[2],
                                      edge_fall_q[1], edge_rise_q[1],
                                      edge_fall_q[0], edge_rise_q[0]};
        `CCT_OFS_IRQ_ENABLE: rdata_q <= {{PAD{1'b0}}, channel_irq_enable_q};
        `CCT_OFS_SYS_CTRL_TWO: rdata_q <= {system_control_two_q.overflow_irq_enable, 4'h0,
                                           system_control_two_q.coarse_divider_select};
        `CCT_OFS_CHAN_FLAGS: rdata_q <= {{PAD{1'b0}}, channel_event_flag_q};
        `CCT_OFS_OVF_FLAGS: rdata_q <= {overflow_flag_q, 7'h00};
        `CCT_OFS_DISCONNECT: rdata_q <= {{PAD{1'b0}}, pin_disconnect_q};
        `CCT_OFS_PRECISION: rdata_q <= precision_prescale_select_q;
        `CCT_OFS_PORT_LATCH: rdata_q <= {{PAD{1'b0}}, port_latch_q};
        default: rdata_q <= `CCT_RST_BYTE;
      endcase
    end
  end

  assign rdata = rdata_q;

endmodule : capture_compare_timer
`default_nettype wire

// >>> hdl/capture_edge_detect.sv
// Pin synchroniser and selectable edge detector for the capture channels
`default_nettype none
module capture_edge_detect #(
  parameter int WIDTH = 6
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] rise_enable,
  input wire logic [WIDTH-1:0] fall_enable,
  output logic [WIDTH-1:0] edge_seen
);

  logic [WIDTH-1:0] sync1_q;
  logic [WIDTH-1:0] sync2_q;
  logic [WIDTH-1:0] prev_q;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Pulses narrower than one clock may be missed
  assign edge_seen = (rise_enable & sync2_q & ~prev_q) | (fall_enable & ~sync2_q & prev_q);

endmodule : capture_edge_detect
`default_nettype wire

// >>> pkg/capture_compare_timer_pkg.sv
// Types shared by the capture/compare timer files
`default_nettype none
package capture_compare_timer_pkg;

  // Compare pin action, coded as {mode, level}
  typedef enum logic [1:0] {
    act_none,
    act_toggle,
    act_clear,
    act_set
  } compare_action_t;

  typedef struct packed {
    logic timer_enable;
    logic fast_flag_clear;
    logic fine_prescale_select;
  } system_control_t;

  typedef struct packed {
    logic overflow_irq_enable;
    logic [2:0] coarse_divider_select;
  } system_control_two_t;

endpackage : capture_compare_timer_pkg
`default_nettype wire

// >>> pkg/capture_compare_timer_regs.svh
// Register offsets, field positions and reset values of the capture/compare timer
`ifndef CAPTURE_COMPARE_TIMER_REGS_SVH
`define CAPTURE_COMPARE_TIMER_REGS_SVH

`define CCT_ADDR_W 6
`define CCT_OFS_DIRECTION 6'h00
`define CCT_OFS_FORCE 6'h01
`define CCT_OFS_COUNT_HI 6'h04
`define CCT_OFS_COUNT_LO 6'h05
`define CCT_OFS_SYS_CTRL_ONE 6'h06
`define CCT_OFS_ACTION_HI 6'h08
`define CCT_OFS_ACTION_LO 6'h09
`define CCT_OFS_EDGE_HI 6'h0a
`define CCT_OFS_EDGE_LO 6'h0b
`define CCT_OFS_IRQ_ENABLE 6'h0c
`define CCT_OFS_SYS_CTRL_TWO 6'h0d
`define CCT_OFS_CHAN_FLAGS 6'h0e
`define CCT_OFS_OVF_FLAGS 6'h0f
`define CCT_OFS_CHAN_BASE_HI 2'h1
`define CCT_OFS_DISCONNECT 6'h2c
`define CCT_OFS_PRECISION 6'h2e
`define CCT_OFS_PORT_LATCH 6'h30

`define CCT_BIT_TEN 7
`define CCT_BIT_FFCA 4
`define CCT_BIT_FINE 3
`define CCT_BIT_OVF_IRQ 7
`define CCT_BIT_OVF_FLAG 7
`define CCT_POS_COARSE 0
`define CCT_W_COARSE 3
`define CCT_PAIRS_PER_BYTE 4

`define CCT_RST_BYTE 8'h00
`define CCT_RST_WORD 16'h0000
`define CCT_COUNT_MAX 16'hffff

`endif

// >>> testbench/capture_compare_timer_props.sv
// Concurrent checks on the ports of the capture/compare timer
`include "capture_compare_timer_regs.svh"
`default_nettype none
module capture_compare_timer_props #(
  parameter int CHANNELS = 6
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [`CCT_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [CHANNELS-1:0] ch_pin_in,
  input wire logic [CHANNELS-1:0] ch_pin_out,
  input wire logic [CHANNELS-1:0] ch_pin_oe_n,
  input wire logic [CHANNELS-1:0] channel_irq,
  input wire logic overflow_irq
);
  // ==========================================
  // Shadow of the control registers
  logic [CHANNELS-1:0] dir_q, ien_q, disc_q, latch_q;
  logic ten_q, ovie_q;
  logic [7:0] prec_q;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      dir_q <= '0;
      ien_q <= '0;
      disc_q <= '0;
      latch_q <= '0;
      prec_q <= 8'h00;
      ten_q <= 1'b0;
      ovie_q <= 1'b0;
    end else if (wr) begin
      case (addr)
        `CCT_OFS_DIRECTION: dir_q <= wdata[CHANNELS-1:0];
        `CCT_OFS_IRQ_ENABLE: ien_q <= wdata[CHANNELS-1:0];
        `CCT_OFS_DISCONNECT: disc_q <= wdata[CHANNELS-1:0];
        `CCT_OFS_PORT_LATCH: latch_q <= wdata[CHANNELS-1:0];
        `CCT_OFS_PRECISION: prec_q <= wdata;
        `CCT_OFS_SYS_CTRL_ONE: ten_q <= wdata[`CCT_BIT_TEN];
        `CCT_OFS_SYS_CTRL_TWO: ovie_q <= wdata[`CCT_BIT_OVF_IRQ];
        default: ;
      endcase
    end
  end
  // ==========================================
  // Assertions
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  chk_oe_follows_dir: assert property (
    $stable(dir_q) |-> ch_pin_oe_n == ~dir_q) else $error("pin enable differs from direction");
  chk_pin_from_latch: assert property (
    !wr [*2] |-> ((ch_pin_out ^ latch_q) & disc_q & dir_q) == '0)
    else $error("disconnected pin differs from port latch");
  chk_irq_masked: assert property (
    (channel_irq & ~ien_q) == '0) else $error("channel interrupt while disabled");
  chk_ovf_masked: assert property (
    overflow_irq |-> ovie_q) else $error("overflow interrupt while disabled");
  chk_clear_held_off: assert property (
    wr && addr == `CCT_OFS_CHAN_FLAGS && !ten_q
    |=> (channel_irq & $past(channel_irq)) == $past(channel_irq))
    else $error("flag cleared with timer off");
  chk_flag_needs_enable: assert property (
    (channel_irq & ~$past(channel_irq)) != '0 |-> ten_q || $past(wr))
    else $error("channel flag set with timer off");
  chk_ovf_needs_enable: assert property (
    $rose(overflow_irq) |-> ten_q || $past(wr)) else $error("overflow with timer off");
  chk_fine_readback: assert property (
    rd && addr == `CCT_OFS_PRECISION |=> rdata == prec_q) else $error("divider readback wrong");
  chk_force_reads_zero: assert property (
    rd && addr == `CCT_OFS_FORCE |=> rdata == 8'h00) else $error("force register not zero");
endmodule : capture_compare_timer_props

bind capture_compare_timer capture_compare_timer_props #(.CHANNELS(CHANNELS)) props_i (
  .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .ch_pin_in(ch_pin_in), .ch_pin_out(ch_pin_out), .ch_pin_oe_n(ch_pin_oe_n),
  .channel_irq(channel_irq), .overflow_irq(overflow_irq));
`default_nettype wire

// >>> testbench/pin_partner.sv
// External signal sources feeding the capture pins
`default_nettype none
module pin_partner (
  input wire logic clock,
  input wire logic [5:0] pulse_go,
  input wire logic [3:0] pulse_len,
  output logic [5:0] drive
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // One pulse timer per pin
  logic [3:0] left_q [6] = '{default: 4'h0};
  always @(posedge clock) begin
    for (int i = 0; i < 6; i++) begin
      if (pulse_go[i]) left_q[i] <= (pulse_len < 4'h3) ? 4'h3 : pulse_len;
      else if (left_q[i] != 4'h0) left_q[i] <= left_q[i] - 4'h1;
    end
  end
  always_comb begin
    for (int i = 0; i < 6; i++) drive[i] = left_q[i] != 4'h0;
  end
endmodule : pin_partner
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the capture/compare timer
`include "capture_compare_timer_regs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Design, far side and pin wiring
  logic clock, rstn, wr, rd, ovf_irq;
  logic [`CCT_ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata;
  logic [5:0] pin_in, pin_out, oe_n, irq, go, far_drive, ien, lat;
  logic [3:0] plen;
  logic [7:0] exp_q [$];
  logic [7:0] fine_tab [4] = '{8'h00, 8'h01, 8'h13, 8'hff};
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int n, t0;
  logic rd_seen = 1'b0;
  capture_compare_timer #(.CHANNELS(6)) uut (.clock(clock), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ch_pin_in(pin_in), .ch_pin_out(pin_out),
    .ch_pin_oe_n(oe_n), .channel_irq(irq), .overflow_irq(ovf_irq));
  pin_partner far_i (.clock(clock), .pulse_go(go), .pulse_len(plen), .drive(far_drive));
  assign pin_in = (~oe_n & pin_out) | (oe_n & far_drive);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;
  always @(posedge clock) begin
    if (rd_seen) compare(rdata, exp_q.pop_front());
    rd_seen <= rd;
  end
  // ==========================================
  // Shared tasks
  task automatic compare(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : compare
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic put(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : put
  task automatic get(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask : get
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask : tick
  task automatic do_reset();
    rstn <= 1'b0;
    tick(12);
    rstn <= 1'b1;
  endtask : do_reset
  task automatic tally_and_finish();
    tick(3);
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // ==========================================
  // Scenarios
  initial begin
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = 8'h00;
    go = 6'h00;
    plen = 4'h3;
    void'($urandom(42));
    do_reset();
    get(`CCT_OFS_PRECISION, 8'h00);
    get(6'h3f, 8'h00);
    get(`CCT_OFS_FORCE, 8'h00);
    // Prescaler: fine table then every coarse code
    for (int c = 0; c < 12; c++) begin
      logic [7:0] fv;
      fv = (c < 4) ? fine_tab[c] : 8'($urandom);
      n = (c < 4) ? fv + 1 : 1 << (c - 4);
      do_reset();
      put(`CCT_OFS_PRECISION, fv);
      get(`CCT_OFS_PRECISION, fv);
      put(`CCT_OFS_SYS_CTRL_TWO, (c < 4) ? 8'($urandom_range(7)) : 8'(c - 4));
      put(`CCT_OFS_SYS_CTRL_ONE, (c < 4) ? 8'h88 : 8'h80);
      tick(4 * n + n / 2 - 1);
      get(`CCT_OFS_COUNT_LO, 8'h04);
      if (c == 3) begin
        put(`CCT_OFS_PRECISION, 8'h00);
        get(`CCT_OFS_COUNT_LO, 8'h04);
      end
    end
    // Capture on every channel, one per prescaled window
    do_reset();
    ien = 6'($urandom);
    put(`CCT_OFS_EDGE_HI, 8'h0e);
    put(`CCT_OFS_EDGE_LO, 8'h55);
    put(`CCT_OFS_IRQ_ENABLE, 8'(ien));
    put(`CCT_OFS_SYS_CTRL_TWO, 8'h07);
    put(`CCT_OFS_SYS_CTRL_ONE, 8'h80);
    t0 = cyc;
    for (int i = 0; i < 6; i++) begin
      while (cyc < t0 + 64 + 128 * (i + 1)) @(posedge clock);
      go <= 6'(1 << i);
      plen <= 4'($urandom_range(9, 3));
      @(posedge clock);
      go <= 6'h00;
    end
    tick(20);
    compare(8'(irq), 8'(ien));
    put(`CCT_OFS_SYS_CTRL_ONE, 8'h00);
    put(`CCT_OFS_CHAN_FLAGS, 8'h3f);
    tick(2);
    compare(8'(irq), 8'(ien));
    put(`CCT_OFS_SYS_CTRL_ONE, 8'h90);
    for (int i = 0; i < 6; i++) begin
      get(6'h10 + 6'(2 * i), 8'h00);
      get(6'h11 + 6'(2 * i), 8'(i + 1));
    end
    tick(2);
    compare(8'(irq), 8'h00);
    // Compare: preset while disconnected, hand-over, then match
    do_reset();
    lat = 6'($urandom);
    put(`CCT_OFS_DIRECTION, 8'h3f);
    put(`CCT_OFS_PORT_LATCH, 8'(lat));
    put(`CCT_OFS_DISCONNECT, 8'h3f);
    put(`CCT_OFS_ACTION_HI, 8'h0b);
    put(`CCT_OFS_ACTION_LO, 8'h1b);
    for (int i = 0; i < 6; i++) begin
      put(6'h10 + 6'(2 * i), 8'h00);
      put(6'h11 + 6'(2 * i), 8'h04);
    end
    put(`CCT_OFS_IRQ_ENABLE, 8'h3f);
    put(`CCT_OFS_SYS_CTRL_TWO, 8'h07);
    put(`CCT_OFS_SYS_CTRL_ONE, 8'h80);
    t0 = cyc;
    tick(2);
    compare(8'(oe_n), 8'h00);
    compare(8'(pin_out), 8'(lat));
    put(`CCT_OFS_FORCE, 8'h3f);
    tick(2);
    compare(8'(pin_out), 8'(lat));
    compare(8'(irq), 8'h00);
    put(`CCT_OFS_DISCONNECT, 8'h20);
    for (int i = 0; i < 4; i++) begin
      compare(8'((pin_out ^ lat) & (pin_out ^ 6'h15)), 8'h00);
      @(posedge clock);
    end
    compare(8'(pin_out), 8'(6'h15 | (lat & 6'h20)));
    while (cyc < t0 + 700) @(posedge clock);
    compare(8'(pin_out), 8'(6'h11 | (lat & 6'h20)));
    compare(8'(irq), 8'h3f);
    put(`CCT_OFS_CHAN_FLAGS, 8'h3f);
    tick(2);
    compare(8'(irq), 8'h00);
    // Counter wrap
    do_reset();
    put(`CCT_OFS_SYS_CTRL_TWO, 8'h80);
    put(`CCT_OFS_SYS_CTRL_ONE, 8'h80);
    n = 0;
    while (ovf_irq !== 1'b1 && n < 70000) begin
      @(posedge clock);
      n++;
    end
    compare(8'(n > 65530 && n < 65540), 8'h01);
    if (n < 70000) begin
      put(`CCT_OFS_OVF_FLAGS, 8'h80);
      tick(2);
      compare(8'(ovf_irq), 8'h00);
    end
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
